// file: frc_freq_ref_regs.sv
// Our own choice: the APB register port.
`timescale 1ns/1ps
module frc_freq_ref_regs #(
  parameter int FREQ_W = 16
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [frc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [FREQ_W-1:0] digitalOpFreq,
  input wire logic [FREQ_W-1:0] voltageInFreq,
  input wire logic [FREQ_W-1:0] networkFreq,
  input wire logic [6:0] knobLevelPct,
  input wire logic [6:0] currentLevelPct,
  input wire logic [6:0] currentStartPct,
  input wire logic [FREQ_W-1:0] currentEndFreq,
  input wire logic [FREQ_W-1:0] freqSetting,
  input wire logic offsetApplyOn,
  output logic [31:0] calcResult,
  output logic [FREQ_W-1:0] knobFreq,
  output logic [FREQ_W-1:0] currentFreq,
  output logic [FREQ_W-1:0] outFreq
);
  // ===========================================================
  // parameter check
  if (FREQ_W != 16)
  begin : g_bad_width
    $error("register words are 16 bits");
  end

  // ===========================================================
  // bus decode
  localparam int N = frc_pkg::NUM_REGS;

  logic [frc_pkg::IDX_W-1:0] accIdx;
  logic aligned;
  logic setupPhase;
  logic accessPhase;
  logic [N-1:0] hitVec;
  logic [N-1:0] okVec;
  logic anyHit;
  logic anyOk;
  logic statHit;
  logic errFf;
  logic nxt_err;
  logic [31:0] prdataFf;
  logic [31:0] nxt_prdata;

  assign accIdx = paddr[frc_pkg::ADDR_W-1:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign setupPhase = psel && !penable;
  assign accessPhase = psel && penable;
  assign anyHit = |hitVec;
  assign anyOk = |okVec;

  // status words are read only
  assign statHit = aligned && (accIdx == frc_pkg::IDX_RESULT_LO
    || accIdx == frc_pkg::IDX_RESULT_HI || accIdx == frc_pkg::IDX_OUT_FREQ);

  // ===========================================================
  // parameter bank
  logic [15:0] bankFf [N];
  logic [N*16-1:0] bankFlat;

  // one entry per parameter, written only with an in-range value
  for (genvar i = 0; i < N; i++)
  begin : g_entry
    assign hitVec[i] = aligned && (accIdx == frc_pkg::REG_IDX[i]);
    assign okVec[i] = hitVec[i] && (pwdata <= {16'h0000, frc_pkg::REG_MAX[i]});
    assign bankFlat[i*16 +: 16] = bankFf[i];

    always_ff @(posedge core_clk or negedge rst_n)
    begin
      if (!rst_n)
        bankFf[i] <= frc_pkg::REG_RST[i];
      else if (accessPhase && pwrite && okVec[i])
        bankFf[i] <= pwdata[15:0];
    end

    a_entry_store: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      accessPhase && pwrite && okVec[i] |=> bankFf[i] == $past(pwdata[15:0]))
      else $error("accepted write not stored");
  end

  // ===========================================================
  // bus answer
  // error decided in setup, shown in access
  always_comb
  begin
    nxt_err = 1'b0;
    if (!anyHit && !statHit)
      nxt_err = 1'b1;
    else if (pwrite && statHit)
      nxt_err = 1'b1;
    else if (pwrite && !anyOk)
      nxt_err = 1'b1;
  end

  // read mux, low half word, upper bits zero
  always_comb
  begin
    nxt_prdata = 32'h0000_0000;
    for (int k = 0; k < N; k++)
    begin
      if (hitVec[k])
        nxt_prdata = {16'h0000, bankFf[k]};
    end
    if (aligned && accIdx == frc_pkg::IDX_RESULT_LO)
      nxt_prdata = {16'h0000, calcResult[15:0]};
    if (aligned && accIdx == frc_pkg::IDX_RESULT_HI)
      nxt_prdata = {16'h0000, calcResult[31:16]};
    if (aligned && accIdx == frc_pkg::IDX_OUT_FREQ)
      nxt_prdata = {16'h0000, outFreq};
  end

  // capture answer in setup cycle
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      errFf <= 1'b0;
      prdataFf <= 32'h0000_0000;
    end
    else if (setupPhase)
    begin
      errFf <= nxt_err;
      prdataFf <= pwrite ? 32'h0000_0000 : nxt_prdata;
    end
  end

  // zero wait states
  assign pready = 1'b1;
  assign pslverr = accessPhase && errFf;
  assign prdata = prdataFf;

  // ===========================================================
  // range scaling of knob and current input
  frc_range_scale #(
    .FREQ_W(FREQ_W)
  ) u_knob_scale (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .levelPct(knobLevelPct),
    .startPct(bankFf[frc_pkg::E_KNOB_START_PCT][6:0]),
    .endPct(bankFf[frc_pkg::E_KNOB_END_PCT][6:0]),
    .startFreq(bankFf[frc_pkg::E_KNOB_START_FREQ]),
    .endFreq(bankFf[frc_pkg::E_KNOB_END_FREQ]),
    .zeroStart(bankFf[frc_pkg::E_KNOB_START_SEL][0] == frc_pkg::SEL_USE_ZERO),
    .freqOut(knobFreq)
  );

  frc_range_scale #(
    .FREQ_W(FREQ_W)
  ) u_current_scale (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .levelPct(currentLevelPct),
    .startPct(currentStartPct),
    .endPct(bankFf[frc_pkg::E_CI_END_PCT][6:0]),
    .startFreq(bankFf[frc_pkg::E_CI_START_FREQ]),
    .endFreq(currentEndFreq),
    .zeroStart(bankFf[frc_pkg::E_CI_START_SEL][0] == frc_pkg::SEL_USE_ZERO),
    .freqOut(currentFreq)
  );

  // ===========================================================
  // two-operand calculation
  frc_calc_unit #(
    .FREQ_W(FREQ_W)
  ) u_calc (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .srcDigital(digitalOpFreq),
    .srcKnob(knobFreq),
    .srcVoltage(voltageInFreq),
    .srcCurrent(currentFreq),
    .srcNetwork(networkFreq),
    .selA(bankFf[frc_pkg::E_OPA_SRC][2:0]),
    .selB(bankFf[frc_pkg::E_OPB_SRC][2:0]),
    .opCode(bankFf[frc_pkg::E_CALC_OP][1:0]),
    .result(calcResult)
  );

  // ===========================================================
  // offset frequency
  logic [FREQ_W-1:0] ofsFreq;
  logic ofsMinus;
  logic [FREQ_W:0] ofsSum;
  logic [FREQ_W-1:0] nxt_outFreq;

  assign ofsFreq = bankFf[frc_pkg::E_OFS_FREQ];
  assign ofsMinus = (bankFf[frc_pkg::E_OFS_DIR][0] == frc_pkg::DIR_MINUS);
  assign ofsSum = {1'b0, freqSetting} + {1'b0, ofsFreq};

  // add saturates high, subtract floors at zero
  always_comb
  begin
    if (!offsetApplyOn)
      nxt_outFreq = freqSetting;
    else if (!ofsMinus)
      nxt_outFreq = ofsSum[FREQ_W] ? '1 : ofsSum[FREQ_W-1:0];
    else if (freqSetting >= ofsFreq)
      nxt_outFreq = freqSetting - ofsFreq;
    else
      nxt_outFreq = '0;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      outFreq <= '0;
    else
      outFreq <= nxt_outFreq;
  end

  // ===========================================================
  // checks
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_setup_bad;
    setupPhase && pwrite && anyHit && !anyOk;
  endsequence

  sequence s_access_done;
    accessPhase && pwrite;
  endsequence

  sequence s_setup_unmapped;
    setupPhase && !anyHit && !statHit;
  endsequence

  a_pct_range: assert property (
    bankFf[frc_pkg::E_CI_END_PCT] <= frc_pkg::PCT_MAX
      && bankFf[frc_pkg::E_KNOB_START_PCT] <= frc_pkg::PCT_MAX
      && bankFf[frc_pkg::E_KNOB_END_PCT] <= frc_pkg::PCT_MAX)
    else $error("percent out of range");

  a_freq_range: assert property (
    bankFf[frc_pkg::E_CI_START_FREQ] <= frc_pkg::FREQ_MAX
      && bankFf[frc_pkg::E_OFS_FREQ] <= frc_pkg::FREQ_MAX
      && bankFf[frc_pkg::E_KNOB_START_FREQ] <= frc_pkg::FREQ_MAX
      && bankFf[frc_pkg::E_KNOB_END_FREQ] <= frc_pkg::FREQ_MAX)
    else $error("frequency out of range");

  a_sel_range: assert property (
    bankFf[frc_pkg::E_CI_START_SEL] <= frc_pkg::SEL_MAX
      && bankFf[frc_pkg::E_OFS_DIR] <= frc_pkg::SEL_MAX
      && bankFf[frc_pkg::E_KNOB_START_SEL] <= frc_pkg::SEL_MAX)
    else $error("select out of range");

  a_code_range: assert property (
    bankFf[frc_pkg::E_OPA_SRC] <= frc_pkg::SRC_MAX
      && bankFf[frc_pkg::E_OPB_SRC] <= frc_pkg::SRC_MAX
      && bankFf[frc_pkg::E_CALC_OP] <= frc_pkg::OP_MAX)
    else $error("code out of range");

  a_invalid_write: assert property (
    s_setup_bad ##1 s_access_done |=> bankFlat == $past(bankFlat) && $past(pslverr))
    else $error("invalid write changed the bank");

  a_valid_write: assert property (
    setupPhase && pwrite && anyOk ##1 s_access_done |-> !pslverr)
    else $error("valid write refused");

  a_ro_write: assert property (
    setupPhase && pwrite && statHit ##1 s_access_done |-> pslverr)
    else $error("read-only write accepted");

  a_bad_addr: assert property (
    s_setup_unmapped ##1 accessPhase |-> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");

  a_offset_add: assert property (
    offsetApplyOn && !ofsMinus && !ofsSum[FREQ_W]
      |=> outFreq == $past(freqSetting) + $past(ofsFreq))
    else $error("offset not added");

  a_offset_sub: assert property (
    offsetApplyOn && ofsMinus && freqSetting >= ofsFreq
      |=> outFreq == $past(freqSetting) - $past(ofsFreq))
    else $error("offset not subtracted");

  a_offset_floor: assert property (
    offsetApplyOn && ofsMinus && freqSetting < ofsFreq |=> outFreq == '0)
    else $error("offset subtract not floored");

  a_offset_off: assert property (
    !offsetApplyOn |=> outFreq == $past(freqSetting))
    else $error("offset applied while terminal off");
endmodule

// file: frc_pkg.sv
package frc_pkg;
  // ===========================================================
  // bus geometry
  localparam int ADDR_W = 16;
  localparam int IDX_W = 14;
  localparam int NUM_REGS = 13;

  // ===========================================================
  // value limits
  localparam logic [15:0] FREQ_MAX = 16'h0FA0;
  localparam logic [15:0] PCT_MAX = 16'h0064;
  localparam logic [15:0] SEL_MAX = 16'h0001;
  localparam logic [15:0] SRC_MAX = 16'h0004;
  localparam logic [15:0] OP_MAX = 16'h0002;
  localparam logic [15:0] ZERO16 = 16'h0000;

  // ===========================================================
  // bank entry numbers
  localparam int E_CI_START_FREQ = 0;
  localparam int E_CI_END_PCT = 1;
  localparam int E_CI_START_SEL = 2;
  localparam int E_OPA_SRC = 3;
  localparam int E_OPB_SRC = 4;
  localparam int E_CALC_OP = 5;
  localparam int E_OFS_FREQ = 6;
  localparam int E_OFS_DIR = 7;
  localparam int E_KNOB_START_FREQ = 8;
  localparam int E_KNOB_END_FREQ = 9;
  localparam int E_KNOB_START_PCT = 10;
  localparam int E_KNOB_END_PCT = 11;
  localparam int E_KNOB_START_SEL = 12;

  // register index, byte address is four times it
  localparam logic [IDX_W-1:0] REG_IDX [NUM_REGS] = '{
    14'h1080, 14'h1084, 14'h1085, 14'h108E, 14'h108F, 14'h1090, 14'h1091,
    14'h1093, 14'h1095, 14'h1097, 14'h1098, 14'h1099, 14'h109A};
  localparam logic [15:0] REG_MAX [NUM_REGS] = '{
    FREQ_MAX, PCT_MAX, SEL_MAX, SRC_MAX, SRC_MAX, OP_MAX, FREQ_MAX,
    SEL_MAX, FREQ_MAX, FREQ_MAX, PCT_MAX, PCT_MAX, SEL_MAX};
  localparam logic [15:0] REG_RST [NUM_REGS] = '{
    ZERO16, PCT_MAX, ZERO16, ZERO16, ZERO16, ZERO16, ZERO16,
    ZERO16, ZERO16, ZERO16, ZERO16, PCT_MAX, ZERO16};

  // read-only status words
  localparam logic [IDX_W-1:0] IDX_RESULT_LO = 14'h10A0;
  localparam logic [IDX_W-1:0] IDX_RESULT_HI = 14'h10A1;
  localparam logic [IDX_W-1:0] IDX_OUT_FREQ = 14'h10A2;

  // ===========================================================
  // codes
  localparam logic [2:0] SRC_DIGITAL = 3'h0;
  localparam logic [2:0] SRC_KNOB = 3'h1;
  localparam logic [2:0] SRC_VOLTAGE = 3'h2;
  localparam logic [2:0] SRC_CURRENT = 3'h3;
  localparam logic [2:0] SRC_NETWORK = 3'h4;
  localparam logic [1:0] OP_ADD = 2'h0;
  localparam logic [1:0] OP_SUB = 2'h1;
  localparam logic [1:0] OP_MULTIPLY = 2'h2;
  localparam logic DIR_PLUS = 1'b0;
  localparam logic DIR_MINUS = 1'b1;
  localparam logic SEL_USE_ZERO = 1'b1;
endpackage

// file: frc_range_scale.sv
`timescale 1ns/1ps
module frc_range_scale #(
  parameter int FREQ_W = 16
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [6:0] levelPct,
  input wire logic [6:0] startPct,
  input wire logic [6:0] endPct,
  input wire logic [FREQ_W-1:0] startFreq,
  input wire logic [FREQ_W-1:0] endFreq,
  input wire logic zeroStart,
  output logic [FREQ_W-1:0] freqOut
);
  // ===========================================================
  // parameter check
  if (FREQ_W < 12)
  begin : g_bad_width
    $error("frequency width too small");
  end

  // ===========================================================
  // interpolation
  logic signed [FREQ_W:0] freqSpan;
  logic signed [8:0] pctStep;
  logic signed [8:0] pctSpan;
  logic signed [FREQ_W+9:0] ramp;
  logic [FREQ_W-1:0] nxt_freq;

  assign freqSpan = $signed({1'b0, endFreq}) - $signed({1'b0, startFreq});
  assign pctStep = $signed({2'b00, levelPct}) - $signed({2'b00, startPct});
  assign pctSpan = $signed({2'b00, endPct}) - $signed({2'b00, startPct});

  // below start, clamp at end, else linear
  always_comb
  begin
    ramp = '0;
    if (levelPct < startPct)
    begin
      nxt_freq = zeroStart ? '0 : startFreq;
    end
    else if (levelPct >= endPct)
    begin
      nxt_freq = endFreq;
    end
    else
    begin
      ramp = ((FREQ_W+10)'(pctStep) * (FREQ_W+10)'(freqSpan)) / (FREQ_W+10)'(pctSpan);
      nxt_freq = FREQ_W'($signed({1'b0, startFreq}) + ramp);
    end
  end

  // registered result
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      freqOut <= '0;
    else
      freqOut <= nxt_freq;
  end

  // ===========================================================
  // checks
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_zero_start: assert property (
    (levelPct < startPct) && zeroStart |=> freqOut == '0)
    else $error("zero start not honoured");
  a_offset_start: assert property (
    (levelPct < startPct) && !zeroStart |=> freqOut == $past(startFreq))
    else $error("start offset not honoured");
endmodule

// file: frc_calc_unit.sv
`timescale 1ns/1ps
module frc_calc_unit #(
  parameter int FREQ_W = 16
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [FREQ_W-1:0] srcDigital,
  input wire logic [FREQ_W-1:0] srcKnob,
  input wire logic [FREQ_W-1:0] srcVoltage,
  input wire logic [FREQ_W-1:0] srcCurrent,
  input wire logic [FREQ_W-1:0] srcNetwork,
  input wire logic [2:0] selA,
  input wire logic [2:0] selB,
  input wire logic [1:0] opCode,
  output logic [31:0] result
);
  // ===========================================================
  // operand selection
  if (2 * FREQ_W > 32)
  begin : g_bad_width
    $error("operands too wide for result");
  end

  logic [2:0] selVec [2];
  logic [FREQ_W-1:0] operand [2];
  logic [31:0] nxt_result;

  assign selVec[0] = selA;
  assign selVec[1] = selB;

  // same source mux for both operands
  for (genvar g = 0; g < 2; g++)
  begin : g_operand
    always_comb
    begin
      case (selVec[g])
        frc_pkg::SRC_DIGITAL: operand[g] = srcDigital;
        frc_pkg::SRC_KNOB: operand[g] = srcKnob;
        frc_pkg::SRC_VOLTAGE: operand[g] = srcVoltage;
        frc_pkg::SRC_CURRENT: operand[g] = srcCurrent;
        frc_pkg::SRC_NETWORK: operand[g] = srcNetwork;
        default: operand[g] = '0;
      endcase
    end
  end

  // ===========================================================
  // operation
  always_comb
  begin
    case (opCode)
      frc_pkg::OP_ADD: nxt_result = 32'(operand[0]) + 32'(operand[1]);
      frc_pkg::OP_SUB: nxt_result = 32'(operand[0]) - 32'(operand[1]);
      frc_pkg::OP_MULTIPLY: nxt_result = 32'(operand[0]) * 32'(operand[1]);
      default: nxt_result = '0;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      result <= '0;
    else
      result <= nxt_result;
  end

  // ===========================================================
  // checks
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_calc_add: assert property (
    opCode == frc_pkg::OP_ADD |=> result == $past(32'(operand[0]) + 32'(operand[1])))
    else $error("add result wrong");
  a_calc_sub: assert property (
    opCode == frc_pkg::OP_SUB |=> result == $past(32'(operand[0]) - 32'(operand[1])))
    else $error("subtract result wrong");
  a_calc_mul: assert property (
    opCode == frc_pkg::OP_MULTIPLY |=> result == $past(32'(operand[0]) * 32'(operand[1])))
    else $error("multiply result wrong");
  a_src_pick: assert property (
    selA == frc_pkg::SRC_KNOB && selB == frc_pkg::SRC_CURRENT
      && opCode == frc_pkg::OP_ADD
      |=> result == $past(32'(srcKnob) + 32'(srcCurrent)))
    else $error("operand source wrong");
endmodule

// file: frc_apb_master.sv
`timescale 1ns/1ps
module frc_apb_master (
  input wire logic core_clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [frc_pkg::ADDR_W-1:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // ==========================================================
  // network master side of the holding registers

  // bus idle from time zero
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0000;
    pwdata = 32'h00000000;
  end

  // one whole word per transfer, held until pready is seen high
  task automatic xfer(input logic wr, input logic [15:0] addr, input logic [31:0] wdata,
                      output logic [31:0] rdata, output logic err);
  begin
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wdata;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1)
    begin
      @(posedge core_clk);
    end
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  end
  endtask
endmodule

// file: tb_frequency_reference_calc_params.sv
`timescale 1ns/1ps
module tb_frequency_reference_calc_params;
  // ==========================================================
  // signals
  logic coreClk, rstN, psel, penable, pwrite, pready, pslverr, offsetApplyOn;
  logic [15:0] paddr, digitalOpFreq, voltageInFreq, networkFreq, currentEndFreq, freqSetting;
  logic [15:0] knobFreq, currentFreq, outFreq;
  logic [31:0] pwdata, prdata, calcResult;
  logic [6:0] knobLevelPct, currentLevelPct, currentStartPct;
  int errCount, samplesChecked, i;

  // operand table: sources, operation, expected result
  localparam logic [2:0] CA [6] = '{3'h0, 3'h0, 3'h2, 3'h1, 3'h4, 3'h3};
  localparam logic [2:0] CB [6] = '{3'h4, 3'h4, 3'h0, 3'h3, 3'h2, 3'h1};
  localparam logic [1:0] CO [6] = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h1, 2'h1};
  localparam logic [31:0] CE [6] = '{32'h0000015E, 32'h000000FA, 32'h000493E0, 32'h00000B22,
    32'hFFFFFC4A, 32'h0000028A};
  // offset table: terminal, direction, offset, expected output
  localparam logic OON [5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
  localparam logic ODR [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
  localparam logic [15:0] OVL [5] = '{16'h00C8, 16'h00C8, 16'h00C8, 16'h0FA0, 16'h0FA0};
  localparam logic [15:0] OEX [5] = '{16'h03E8, 16'h04B0, 16'h0320, 16'h0000, 16'h03E8};

  // ==========================================================
  // design and master
  frc_freq_ref_regs #(.FREQ_W(16)) u_dut (.core_clk(coreClk), .rst_n(rstN), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .digitalOpFreq(digitalOpFreq), .voltageInFreq(voltageInFreq),
    .networkFreq(networkFreq), .knobLevelPct(knobLevelPct), .currentLevelPct(currentLevelPct),
    .currentStartPct(currentStartPct), .currentEndFreq(currentEndFreq), .freqSetting(freqSetting),
    .offsetApplyOn(offsetApplyOn), .calcResult(calcResult), .knobFreq(knobFreq),
    .currentFreq(currentFreq), .outFreq(outFreq));
  frc_apb_master u_master (.core_clk(coreClk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // clock, 10 ns period
  initial
  begin
    coreClk = 1'b0;
  end
  always #5 coreClk = ~coreClk;

  // ==========================================================
  // helpers
  function automatic logic [15:0] ba(input int e);
    return {frc_pkg::REG_IDX[e], 2'b00};
  endfunction

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
  begin
    samplesChecked++;
    if (seen !== exp)
    begin
      errCount++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  end
  endtask

  task automatic regWr(input logic [15:0] addr, input logic [31:0] data, input logic expErr);
    logic [31:0] rd;
    logic er;
  begin
    u_master.xfer(1'b1, addr, data, rd, er);
    check("write error flag", {31'h00000000, er}, {31'h00000000, expErr});
  end
  endtask

  task automatic regRd(input logic [15:0] addr, input logic [31:0] exp, input logic expErr);
    logic [31:0] rd;
    logic er;
  begin
    u_master.xfer(1'b0, addr, 32'h00000000, rd, er);
    check("read data", rd, exp);
    check("read error flag", {31'h00000000, er}, {31'h00000000, expErr});
  end
  endtask

  // outputs follow inputs within two edges
  task automatic settle;
    repeat (3) @(posedge coreClk);
  endtask

  task automatic results;
  begin
    $display("comparisons %0d mismatches %0d", samplesChecked, errCount);
    if (errCount == 0 && samplesChecked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask

  // watchdog against a hung transfer
  initial
  begin
    repeat (20000) @(posedge coreClk);
    errCount++;
    results();
  end

  // ==========================================================
  // main sequence
  initial
  begin
    errCount = 0;
    samplesChecked = 0;
    rstN = 1'b0;
    digitalOpFreq = 16'h012C;
    voltageInFreq = 16'h03E8;
    networkFreq = 16'h0032;
    knobLevelPct = 7'h00;
    currentLevelPct = 7'h00;
    currentStartPct = 7'h0A;
    currentEndFreq = 16'h0BB8;
    freqSetting = 16'h03E8;
    offsetApplyOn = 1'b0;
    repeat (3) @(posedge coreClk);
    rstN <= 1'b1;
    @(posedge coreClk);
    // reset values, then range limits of every register
    for (i = 0; i < frc_pkg::NUM_REGS; i++)
    begin
      regRd(ba(i), {16'h0000, frc_pkg::REG_RST[i]}, 1'b0);
      regWr(ba(i), {16'h0000, frc_pkg::REG_MAX[i]}, 1'b0);
      regRd(ba(i), {16'h0000, frc_pkg::REG_MAX[i]}, 1'b0);
      regWr(ba(i), {16'h0000, frc_pkg::REG_MAX[i] + 16'h0001}, 1'b1);
      regWr(ba(i), 32'h00010000, 1'b1);
      regRd(ba(i), {16'h0000, frc_pkg::REG_MAX[i]}, 1'b0);
    end
    // unmapped, misaligned and read-only places
    regRd(16'h4204, 32'h00000000, 1'b1);
    regRd(16'h4211, 32'h00000000, 1'b1);
    regWr({frc_pkg::IDX_RESULT_LO, 2'b00}, 32'h00000001, 1'b1);
    // knob range scaling
    regWr(ba(frc_pkg::E_KNOB_START_FREQ), 32'h00000064, 1'b0);
    regWr(ba(frc_pkg::E_KNOB_END_FREQ), 32'h00000834, 1'b0);
    regWr(ba(frc_pkg::E_KNOB_START_PCT), 32'h00000014, 1'b0);
    regWr(ba(frc_pkg::E_KNOB_END_PCT), 32'h00000046, 1'b0);
    regWr(ba(frc_pkg::E_KNOB_START_SEL), 32'h00000001, 1'b0);
    knobLevelPct <= 7'h0A;
    settle();
    check("knob below start zero", {16'h0000, knobFreq}, 32'h00000000);
    regWr(ba(frc_pkg::E_KNOB_START_SEL), 32'h00000000, 1'b0);
    settle();
    check("knob below start offset", {16'h0000, knobFreq}, 32'h00000064);
    knobLevelPct <= 7'h46;
    settle();
    check("knob at end", {16'h0000, knobFreq}, 32'h00000834);
    knobLevelPct <= 7'h2D;
    settle();
    check("knob midway", {16'h0000, knobFreq}, 32'h0000044C);
    // current input range scaling
    regWr(ba(frc_pkg::E_CI_START_FREQ), 32'h000001F4, 1'b0);
    regWr(ba(frc_pkg::E_CI_END_PCT), 32'h0000003C, 1'b0);
    regWr(ba(frc_pkg::E_CI_START_SEL), 32'h00000001, 1'b0);
    currentLevelPct <= 7'h05;
    settle();
    check("current below start zero", {16'h0000, currentFreq}, 32'h00000000);
    regWr(ba(frc_pkg::E_CI_START_SEL), 32'h00000000, 1'b0);
    settle();
    check("current below start offset", {16'h0000, currentFreq}, 32'h000001F4);
    currentLevelPct <= 7'h23;
    settle();
    check("current midway", {16'h0000, currentFreq}, 32'h000006D6);
    // operand sources and operations
    for (i = 0; i < 6; i++)
    begin
      regWr(ba(frc_pkg::E_OPA_SRC), {29'h00000000, CA[i]}, 1'b0);
      regWr(ba(frc_pkg::E_OPB_SRC), {29'h00000000, CB[i]}, 1'b0);
      regWr(ba(frc_pkg::E_CALC_OP), {30'h00000000, CO[i]}, 1'b0);
      settle();
      check("calc result", calcResult, CE[i]);
      regRd({frc_pkg::IDX_RESULT_LO, 2'b00}, {16'h0000, CE[i][15:0]}, 1'b0);
      regRd({frc_pkg::IDX_RESULT_HI, 2'b00}, {16'h0000, CE[i][31:16]}, 1'b0);
    end
    // offset terminal and direction
    for (i = 0; i < 5; i++)
    begin
      regWr(ba(frc_pkg::E_OFS_FREQ), {16'h0000, OVL[i]}, 1'b0);
      regWr(ba(frc_pkg::E_OFS_DIR), {31'h00000000, ODR[i]}, 1'b0);
      offsetApplyOn <= OON[i];
      settle();
      check("offset output", {16'h0000, outFreq}, {16'h0000, OEX[i]});
      regRd({frc_pkg::IDX_OUT_FREQ, 2'b00}, {16'h0000, OEX[i]}, 1'b0);
    end
    results();
  end
endmodule
